//--- verilog/bhp_cfg.svh
`ifndef BHP_CFG_SVH
`define BHP_CFG_SVH

// ----------------------------------------------------------------
// strap encodings
// ----------------------------------------------------------------
`define BHP_MODE_SEP_STROBE 3'h3
`define BHP_ENDIAN_BIG 1'h1
`define BHP_POL_HIGH 1'h1

// ----------------------------------------------------------------
// host controller registers (byte addresses on avalon)
// ----------------------------------------------------------------
`define BHP_REG_CTRL 4'h0
`define BHP_REG_ADDR 4'h4
`define BHP_REG_WDATA 4'h8
`define BHP_REG_RDATA 4'hC
// ctrl: bit0 start, bit1 write, bit2 low lane, bit3 high lane,
// bit4 memory/register select; status (read of ctrl): bit8 busy,
// bit9 done
`define BHP_CTRL_START 0
`define BHP_CTRL_WRITE 1
`define BHP_CTRL_LO 2
`define BHP_CTRL_HI 3
`define BHP_CTRL_MEM 4
`define BHP_STAT_BUSY 8
`define BHP_STAT_DONE 9

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BHP_RST_DATA 16'h0000
`define BHP_RST_ADDR 17'h00000

`endif

//--- verilog/bhp_pkg.sv
`default_nettype none
package bhp_pkg;
    typedef enum logic [1:0] {
        BHP_D_IDLE,
        BHP_D_ARB,
        BHP_D_HOLD
    } bhp_dev_state_t;

    typedef enum logic [1:0] {
        BHP_H_IDLE,
        BHP_H_SETUP,
        BHP_H_STROBE,
        BHP_H_END
    } bhp_host_state_t;
endpackage : bhp_pkg
`default_nettype wire

//--- verilog/bhp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bhp_if;
    logic [16:0] host_addr_in;
    logic [15:0] host_dq_out;
    logic host_dq_oe;
    logic [15:0] dev_dq_out;
    logic dev_dq_oe;
    logic [15:0] host_data_io;
    logic chip_select_n;
    logic mem_reg_sel;
    logic low_byte_write_n;
    logic high_byte_write_n;
    logic low_byte_read_n;
    logic high_byte_read_n;
    logic cycle_start_strobe_n;
    logic hold_off;
    logic [2:0] bus_mode_straps;
    logic endian_strap;
    logic hold_off_polarity_strap;

    // bus level resolved from enables; device wins on a clash
    assign host_data_io = dev_dq_oe ? dev_dq_out :
                          (host_dq_oe ? host_dq_out : 16'hFFFF);

    modport device (
        input host_addr_in, host_data_io, chip_select_n, mem_reg_sel,
        input low_byte_write_n, high_byte_write_n, low_byte_read_n,
        input high_byte_read_n, cycle_start_strobe_n,
        input bus_mode_straps, endian_strap, hold_off_polarity_strap,
        output dev_dq_out, dev_dq_oe, hold_off
    );
    modport host (
        input host_data_io, hold_off,
        output host_addr_in, host_dq_out, host_dq_oe, chip_select_n,
        output mem_reg_sel, low_byte_write_n, high_byte_write_n,
        output low_byte_read_n, high_byte_read_n, cycle_start_strobe_n,
        output bus_mode_straps, endian_strap, hold_off_polarity_strap
    );
endinterface : bhp_if
`default_nettype wire

//--- verilog/bhp_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "bhp_cfg.svh"
module bhp_device
    import bhp_pkg::*;
(
    input wire logic input_clock_pin,
    input wire logic rst,
    bhp_if.device bus,
    output logic res_req,
    output logic res_we,
    output logic res_mem,
    output logic [16:0] res_addr,
    output logic [15:0] res_wdata,
    output logic [1:0] res_be,
    input wire logic res_gnt,
    input wire logic [15:0] res_rdata,
    output logic mode_ok,
    output logic big_endian
);
    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    logic [4:0] strap_s1_r;
    logic [4:0] strap_s2_r;
    logic rst_d_r;
    logic pol_high_r;
    logic mode_ok_r;
    logic big_endian_r;
    logic release_w;
    logic pol_now_w;

    assign release_w = rst_d_r & ~rst;
    // the strap taken at this very edge already sets the idle level, so
    // no false acknowledge follows reset
    assign pol_now_w = release_w ? strap_s2_r[4] == `BHP_POL_HIGH :
                       pol_high_r;

    always_ff @(posedge input_clock_pin) begin
        strap_s1_r <= {bus.hold_off_polarity_strap, bus.endian_strap,
                       bus.bus_mode_straps};
        strap_s2_r <= strap_s1_r;
        rst_d_r <= rst;
    end

    // straps are taken once, on the first edge after reset falls
    always_ff @(posedge input_clock_pin) begin
        if (rst) begin
            mode_ok_r <= 1'b0;
            big_endian_r <= 1'b0;
            pol_high_r <= 1'b0;
        end else if (release_w) begin
            mode_ok_r <= strap_s2_r[2:0] == `BHP_MODE_SEP_STROBE;
            big_endian_r <= strap_s2_r[3] == `BHP_ENDIAN_BIG;
            pol_high_r <= strap_s2_r[4] == `BHP_POL_HIGH;
        end
    end

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    // the host is clocked by the same clock, so its pins are used
    // without synchronisers
    logic selected_w;
    logic wr_lo_w;
    logic wr_hi_w;
    logic rd_any_w;
    logic rd_off_w;
    logic start_w;
    logic [15:0] lane_in_w;
    logic [15:0] lane_out_w;

    assign selected_w = mode_ok_r & ~bus.chip_select_n;
    assign wr_lo_w = ~bus.low_byte_write_n;
    assign wr_hi_w = ~bus.high_byte_write_n;
    assign rd_any_w = ~bus.low_byte_read_n | ~bus.high_byte_read_n;
    assign rd_off_w = bus.low_byte_read_n & bus.high_byte_read_n;
    assign start_w = selected_w & (wr_lo_w | wr_hi_w | rd_any_w);
    // little endian setting swaps lanes; big endian passes through
    assign lane_in_w = big_endian_r ? bus.host_data_io :
                       {bus.host_data_io[7:0], bus.host_data_io[15:8]};
    assign lane_out_w = big_endian_r ? res_rdata :
                        {res_rdata[7:0], res_rdata[15:8]};

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    bhp_dev_state_t state_r;
    bhp_dev_state_t state_nxt;
    logic ready_r;
    logic [15:0] dq_r;
    logic dq_oe_r;
    logic hold_off_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BHP_D_IDLE: begin
                if (start_w) begin
                    state_nxt = BHP_D_ARB;
                end
            end
            BHP_D_ARB: begin
                if (res_gnt) begin
                    state_nxt = BHP_D_HOLD;
                end
            end
            BHP_D_HOLD: begin
                // wait for all strobes or the select to release before rearming
                if (bus.chip_select_n | (rd_off_w & bus.low_byte_write_n
                        & bus.high_byte_write_n)) begin
                    state_nxt = BHP_D_IDLE;
                end
            end
            default: begin
                state_nxt = BHP_D_IDLE;
            end
        endcase
    end

    always_ff @(posedge input_clock_pin) begin
        if (rst) begin
            state_r <= BHP_D_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // request toward the internal arbiter; fields taken at start
    always_ff @(posedge input_clock_pin) begin
        if (rst) begin
            res_req <= 1'b0;
            res_we <= 1'b0;
            res_mem <= 1'b0;
            res_addr <= `BHP_RST_ADDR;
            res_wdata <= `BHP_RST_DATA;
            res_be <= 2'h0;
        end else if (state_r == BHP_D_IDLE && start_w) begin
            res_req <= 1'b1;
            res_we <= ~rd_any_w;
            res_mem <= bus.mem_reg_sel;
            res_addr <= bus.host_addr_in;
            res_wdata <= lane_in_w;
            // reads always fetch both lanes
            res_be <= rd_any_w ? 2'h3 : {wr_hi_w, wr_lo_w};
        end else if (state_r == BHP_D_ARB && res_gnt) begin
            res_req <= 1'b0;
        end
    end

    // one-cycle ready when arbitration completes
    always_ff @(posedge input_clock_pin) begin
        if (rst) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= state_r == BHP_D_ARB && res_gnt;
        end
    end

    // read data stands from ready until the read strobes release,
    // and never drops in the acknowledge cycle itself
    always_ff @(posedge input_clock_pin) begin
        if (rst) begin
            dq_r <= `BHP_RST_DATA;
            dq_oe_r <= 1'b0;
        end else if (state_r == BHP_D_ARB && res_gnt && !res_we) begin
            dq_r <= lane_out_w;
            dq_oe_r <= 1'b1;
        end else if (!ready_r && (rd_off_w | bus.chip_select_n)) begin
            dq_oe_r <= 1'b0;
        end
    end

    // pin sense: polarity high drives the ready level high, so the
    // host takes that high level, gated by its select, as the acknowledge
    always_ff @(posedge input_clock_pin) begin
        if (rst) begin
            hold_off_r <= 1'b0;
        end else begin
            hold_off_r <= (state_r == BHP_D_ARB && res_gnt) ?
                          pol_now_w : ~pol_now_w;
        end
    end

    assign bus.hold_off = hold_off_r;
    assign bus.dev_dq_out = dq_r;
    assign bus.dev_dq_oe = dq_oe_r;
    assign mode_ok = mode_ok_r;
    assign big_endian = big_endian_r;
endmodule : bhp_device
`default_nettype wire

//--- verilog/bhp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "bhp_cfg.svh"
module bhp_host
    import bhp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    bhp_if.host bus,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // ------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------
    logic wait_r;
    logic [31:0] rdata_r;
    logic [4:0] ctrl_r;
    logic [16:0] addr_r;
    logic [15:0] wdata_r;
    logic [15:0] rd_r;
    logic done_r;
    logic busy_w;
    logic acc_w;
    logic wr_ctrl_w;
    logic start_w;
    logic [31:0] rmux_w;
    bhp_host_state_t state_r;
    bhp_host_state_t state_nxt;

    assign busy_w = state_r != BHP_H_IDLE;
    assign acc_w = (avs_read | avs_write) & ~wait_r;
    assign wr_ctrl_w = avs_write & ~wait_r &
                       avs_address == `BHP_REG_CTRL;
    // a start while busy is dropped
    assign start_w = wr_ctrl_w & avs_writedata[`BHP_CTRL_START] & ~busy_w;
    assign rmux_w = avs_address == `BHP_REG_CTRL ?
                    {22'h0, done_r, busy_w, 3'h0, ctrl_r} :
                    avs_address == `BHP_REG_ADDR ? {15'h0, addr_r} :
                    avs_address == `BHP_REG_WDATA ? {16'h0, wdata_r} :
                    avs_address == `BHP_REG_RDATA ? {16'h0, rd_r} :
                    32'h0;

    // every access answers on the second edge
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0;
        end else begin
            wait_r <= ~((avs_read | avs_write) & wait_r);
            if (avs_read & wait_r) begin
                rdata_r <= rmux_w;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= 5'h0;
            addr_r <= `BHP_RST_ADDR;
            wdata_r <= `BHP_RST_DATA;
        end else if (avs_write & acc_w & ~busy_w) begin
            if (avs_address == `BHP_REG_CTRL) begin
                ctrl_r <= {avs_writedata[4:1], 1'b0};
            end
            if (avs_address == `BHP_REG_ADDR) begin
                addr_r <= avs_writedata[16:0];
            end
            if (avs_address == `BHP_REG_WDATA) begin
                wdata_r <= avs_writedata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // chip-select bus cycle
    // ------------------------------------------------------------
    // big-endian numbered view of the address: bit 0 most significant
    logic [0:31] cpu_addr_w;
    logic [16:0] pin_addr_w;
    logic ack_w;

    assign cpu_addr_w = {15'h0, addr_r};
    genvar gi;
    generate
        for (gi = 0; gi < 17; gi = gi + 1) begin : g_rev
            assign pin_addr_w[gi] = cpu_addr_w[31 - gi];
        end
    endgenerate
    // select gate, no inverter, in front of the active-high acknowledge input
    assign ack_w = ~bus.chip_select_n & bus.hold_off;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BHP_H_IDLE: begin
                if (start_w) begin
                    state_nxt = BHP_H_SETUP;
                end
            end
            BHP_H_SETUP: begin
                state_nxt = BHP_H_STROBE;
            end
            BHP_H_STROBE: begin
                if (ack_w) begin
                    state_nxt = BHP_H_END;
                end
            end
            BHP_H_END: begin
                state_nxt = BHP_H_IDLE;
            end
            default: begin
                state_nxt = BHP_H_IDLE;
            end
        endcase
    end

    logic cs_n_r;
    logic wl_n_r;
    logic wh_n_r;
    logic rd_n_r;
    logic [16:0] pa_r;
    logic msel_r;
    logic dq_oe_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= BHP_H_IDLE;
            cs_n_r <= 1'b1;
            wl_n_r <= 1'b1;
            wh_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            pa_r <= `BHP_RST_ADDR;
            msel_r <= 1'b0;
            dq_oe_r <= 1'b0;
            rd_r <= `BHP_RST_DATA;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (start_w) begin
                pa_r <= pin_addr_w;
                msel_r <= avs_writedata[`BHP_CTRL_MEM];
                cs_n_r <= 1'b0;
                dq_oe_r <= avs_writedata[`BHP_CTRL_WRITE];
                done_r <= 1'b0;
            end
            if (state_r == BHP_H_SETUP) begin
                wl_n_r <= ~(ctrl_r[`BHP_CTRL_WRITE] &
                            ctrl_r[`BHP_CTRL_LO]);
                wh_n_r <= ~(ctrl_r[`BHP_CTRL_WRITE] &
                            ctrl_r[`BHP_CTRL_HI]);
                rd_n_r <= ctrl_r[`BHP_CTRL_WRITE];
            end
            if (state_r == BHP_H_STROBE && ack_w) begin
                if (!ctrl_r[`BHP_CTRL_WRITE]) begin
                    rd_r <= bus.host_data_io;
                end
                wl_n_r <= 1'b1;
                wh_n_r <= 1'b1;
                rd_n_r <= 1'b1;
            end
            if (state_r == BHP_H_END) begin
                cs_n_r <= 1'b1;
                dq_oe_r <= 1'b0;
                done_r <= 1'b1;
            end
        end
    end

    assign bus.host_addr_in = pa_r;
    assign bus.host_dq_out = wdata_r;
    assign bus.host_dq_oe = dq_oe_r;
    assign bus.chip_select_n = cs_n_r;
    assign bus.mem_reg_sel = msel_r;
    assign bus.low_byte_write_n = wl_n_r;
    assign bus.high_byte_write_n = wh_n_r;
    assign bus.low_byte_read_n = rd_n_r;
    assign bus.high_byte_read_n = rd_n_r;
    assign bus.cycle_start_strobe_n = 1'b1;
    assign bus.bus_mode_straps = `BHP_MODE_SEP_STROBE;
    assign bus.endian_strap = `BHP_ENDIAN_BIG;
    assign bus.hold_off_polarity_strap = `BHP_POL_HIGH;
    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
endmodule : bhp_host
`default_nettype wire

//--- verification/bhp_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module bhp_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] host_data_io,
    input wire logic chip_select_n,
    input wire logic mem_reg_sel,
    input wire logic low_byte_write_n,
    input wire logic high_byte_write_n,
    input wire logic low_byte_read_n,
    input wire logic high_byte_read_n,
    input wire logic dev_dq_oe,
    input wire logic hold_off,
    input wire logic res_req,
    input wire logic res_gnt,
    input wire logic res_we,
    input wire logic res_mem,
    input wire logic [1:0] res_be,
    input wire logic [15:0] res_wdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // acknowledge timing
    // ----------------------------------------------------------------
    property p_ack_after_gnt;
        res_req && res_gnt |=> hold_off;
    endproperty
    a_ack_after_gnt: assert property (p_ack_after_gnt)
        else $error("no acknowledge after grant");
    property p_ack_needs_gnt;
        hold_off |-> $past(res_gnt);
    endproperty
    a_ack_needs_gnt: assert property (p_ack_needs_gnt)
        else $error("acknowledge before arbitration finished");
    property p_ack_one;
        hold_off |=> !hold_off;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("acknowledge longer than one cycle");
    property p_ack_cs;
        hold_off |-> !chip_select_n;
    endproperty
    a_ack_cs: assert property (p_ack_cs)
        else $error("acknowledge outside a selected access");
    property p_req_hold;
        res_req && !res_gnt |=> res_req;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before grant");

    // ----------------------------------------------------------------
    // data bus and access steering
    // ----------------------------------------------------------------
    property p_rd_drive;
        hold_off && !low_byte_read_n && !high_byte_read_n |-> dev_dq_oe;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("read data not driven at acknowledge");
    property p_rd_keep;
        $fell(dev_dq_oe) |->
            $past(low_byte_read_n && high_byte_read_n || chip_select_n);
    endproperty
    a_rd_keep: assert property (p_rd_keep)
        else $error("read data released while strobes low");
    property p_rd_release;
        $rose(low_byte_read_n) |-> ##[0:2] !dev_dq_oe;
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("data bus not released after read");
    property p_wr_quiet;
        !(low_byte_write_n && high_byte_write_n) |-> !dev_dq_oe;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet)
        else $error("device drives bus during write");
    property p_rd_full;
        res_req && !res_we |-> res_be == 2'h3;
    endproperty
    a_rd_full: assert property (p_rd_full)
        else $error("read not full width");
    property p_sel_steer;
        $rose(res_req) |-> res_mem == mem_reg_sel && !chip_select_n;
    endproperty
    a_sel_steer: assert property (p_sel_steer)
        else $error("access steered to wrong block");
    property p_wr_take;
        $rose(res_req) && res_we |-> res_wdata == host_data_io &&
            res_be == ~{high_byte_write_n, low_byte_write_n};
    endproperty
    a_wr_take: assert property (p_wr_take)
        else $error("write lanes or data not taken from bus");
endmodule : bhp_asserts
`default_nettype wire

//--- verification/test_byte_strobe_host_bus_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "bhp_cfg.svh"
module test_byte_strobe_host_bus_port;
    logic clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, seed, r;
    logic res_req, res_we, res_mem, res_gnt, mode_ok, big_endian;
    logic [16:0] res_addr;
    logic [15:0] res_wdata, res_rdata, cur;
    logic [1:0] res_be;
    logic [15:0] dut_mem [logic [17:0]];
    logic [15:0] ref_mem [logic [17:0]];
    logic e_we, e_mem;
    logic [16:0] e_addr;
    logic [15:0] e_data;
    logic [1:0] e_be;
    int n_mismatch, n_checks, dly;

    bhp_if bus_if();
    bhp_host bhp_host_i (.clk(clk), .rst(rst), .bus(bus_if.host),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    bhp_device bhp_device_i (.input_clock_pin(clk), .rst(rst),
        .bus(bus_if.device), .res_req(res_req), .res_we(res_we),
        .res_mem(res_mem), .res_addr(res_addr), .res_wdata(res_wdata),
        .res_be(res_be), .res_gnt(res_gnt), .res_rdata(res_rdata),
        .mode_ok(mode_ok), .big_endian(big_endian));
    bhp_asserts bhp_asserts_i (.clk(clk), .rst(rst),
        .host_data_io(bus_if.host_data_io),
        .chip_select_n(bus_if.chip_select_n),
        .mem_reg_sel(bus_if.mem_reg_sel),
        .low_byte_write_n(bus_if.low_byte_write_n),
        .high_byte_write_n(bus_if.high_byte_write_n),
        .low_byte_read_n(bus_if.low_byte_read_n),
        .high_byte_read_n(bus_if.high_byte_read_n),
        .dev_dq_oe(bus_if.dev_dq_oe), .hold_off(bus_if.hold_off),
        .res_req(res_req), .res_gnt(res_gnt), .res_we(res_we),
        .res_mem(res_mem), .res_be(res_be), .res_wdata(res_wdata));

    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task end_sim();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // request held until waitrequest is sampled low
    task av(input logic wr, input logic [3:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        repeat (64) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        // a slave that never answers is a failure, not a silent pass
        if (avs_waitrequest !== 1'b0) n_mismatch++;
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av

    task op(input logic m, input logic w, input logic [16:0] a,
            input logic [15:0] d, input logic [1:0] be);
        logic [31:0] q;
        logic [15:0] old;
        e_mem = m;
        e_we = w;
        e_addr = a;
        e_data = d;
        e_be = w ? be : 2'h3;
        av(1'b1, `BHP_REG_ADDR, {15'h0000, a}, q);
        av(1'b1, `BHP_REG_WDATA, {16'h0000, d}, q);
        av(1'b1, `BHP_REG_CTRL, {27'h0000000, m, be, w, 1'b1}, q);
        // a rewrite while busy must not reach the pins
        av(1'b1, `BHP_REG_ADDR, {15'h0000, ~a}, q);
        repeat (64) begin
            av(1'b0, `BHP_REG_CTRL, 32'h00000000, q);
            if (q[`BHP_STAT_BUSY] === 1'b0) break;
        end
        check("done", q[`BHP_STAT_DONE], 32'h1);
        old = ref_mem.exists({m, a}) ? ref_mem[{m, a}] : 16'h0000;
        if (w) begin
            ref_mem[{m, a}] = {be[1] ? d[15:8] : old[15:8],
                               be[0] ? d[7:0] : old[7:0]};
        end else begin
            av(1'b0, `BHP_REG_RDATA, 32'h00000000, q);
            check("read data", q, {16'h0000, old});
        end
    endtask : op

    // ----------------------------------------------------------------
    // arbitration and storage behind the device
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        res_gnt <= 1'b0;
        res_rdata <= seed[15:0];
        if (rst) begin
            dly <= 0;
        end else if (res_req && !res_gnt) begin
            if (dly > 0) begin
                dly <= dly - 1;
            end else begin
                res_gnt <= 1'b1;
                dly <= int'(xs() % 6);
                cur = dut_mem.exists({res_mem, res_addr}) ?
                      dut_mem[{res_mem, res_addr}] : 16'h0000;
                res_rdata <= cur;
                if (res_we) begin
                    dut_mem[{res_mem, res_addr}] = {
                        res_be[1] ? res_wdata[15:8] : cur[15:8],
                        res_be[0] ? res_wdata[7:0] : cur[7:0]};
                end
                check("cs", bus_if.chip_select_n, 32'h0);
                check("bs", bus_if.cycle_start_strobe_n, 32'h1);
                check("pins", bus_if.host_addr_in, e_addr);
                check("msel", bus_if.mem_reg_sel, e_mem);
                check("wr",
                    {bus_if.high_byte_write_n, bus_if.low_byte_write_n},
                    e_we ? e_be ^ 2'h3 : 2'h3);
                check("rd", {bus_if.high_byte_read_n, bus_if.low_byte_read_n},
                    e_we ? 2'h3 : 2'h0);
                check("req", {res_we, res_mem, res_be, res_addr},
                    {e_we, e_mem, e_be, e_addr});
                if (e_we) check("wdata", res_wdata, e_data);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        seed = 32'h00000012;
        rst = 1'b1;
        {avs_read, avs_write, res_gnt} = 3'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h00000000;
        res_rdata = 16'h0000;
        n_mismatch = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check("mode", mode_ok, 32'h1);
        check("endian", big_endian, 32'h1);
        check("idle ack", bus_if.hold_off, 32'h0);
        av(1'b0, 4'h2, 32'h00000000, r);
        check("unmapped", r, 32'h00000000);
        $display("test reset done");
        op(1'b0, 1'b1, 17'h00005, 16'hA55A, 2'h3);
        op(1'b1, 1'b1, 17'h00005, 16'h5AA5, 2'h3);
        op(1'b0, 1'b0, 17'h00005, 16'h0000, 2'h3);
        op(1'b1, 1'b0, 17'h00005, 16'h0000, 2'h3);
        $display("test blocks done");
        op(1'b1, 1'b1, 17'h1FFFF, 16'h1234, 2'h1);
        op(1'b1, 1'b1, 17'h1FFFF, 16'h5678, 2'h2);
        op(1'b1, 1'b0, 17'h1FFFF, 16'h0000, 2'h3);
        $display("test lanes done");
        for (int i = 0; i < 60; i++) begin
            r = xs();
            op(r[0], r[1], {r[16], 12'h000, r[5:2]}, r[31:16],
               r[7:6] == 2'h0 ? 2'h3 : r[7:6]);
        end
        $display("test random done");
        end_sim();
    end
endmodule : test_byte_strobe_host_bus_port
`default_nettype wire
